// ===== reset_seq_pkg.sv
package reset_seq_pkg;

    // Length of the internal reset procedure in clock cycles
    localparam int RESET_CYCLES_DEFAULT = 16;

    // Watchdog timing: one state per clock, watchdog ticks at clock / 2
    localparam int WDT_OVF_STATES  = 131072;
    localparam int STATE_CLKS      = 1;
    localparam int WDT_OVF_CYCLES  = WDT_OVF_STATES * STATE_CLKS;
    localparam int WDT_PRESCALE    = 2;
    localparam logic [7:0] WDT_RELOAD = 8'h00;

    // Restart point after reset
    localparam logic [15:0] FETCH_ADDR_RESET = 16'h0000;
    localparam logic [1:0]  FETCH_SEG_RESET  = 2'h0;

    // Special function register defaults
    localparam logic [9:0]  DATA_PAGE_PTR_0_RESET  = 10'h000;
    localparam logic [9:0]  DATA_PAGE_PTR_1_RESET  = 10'h001;
    localparam logic [9:0]  DATA_PAGE_PTR_2_RESET  = 10'h002;
    localparam logic [9:0]  DATA_PAGE_PTR_3_RESET  = 10'h003;
    localparam logic [15:0] CP_RESET    = 16'hFC00;
    localparam logic [15:0] SP_RESET    = 16'hFC00;
    localparam logic [15:0] STACK_UNDERFLOW_LIMIT_RESET = 16'hFC00;
    localparam logic [15:0] STACK_OVERFLOW_LIMIT_RESET = 16'hFA00;
    localparam logic [15:0] SYSTEM_CONFIG_REG_BASE = 16'h0000;
    localparam logic [15:0] WDT_CONTROL_REG_RESET = 16'h0000;

    // Field positions
    localparam int SYSTEM_CONFIG_REG_BTYP_POS  = 6;
    localparam int SYSTEM_CONFIG_REG_ROM_ENABLE_BIT_POS = 10;
    localparam int WDT_CONTROL_REG_FLAG_POS  = 1;
    localparam int WDT_CONTROL_REG_RELOAD_POS = 8;

    // Bus type code of single-chip mode
    localparam logic [1:0] BUS_SINGLE_CHIP = 2'h0;

    typedef enum logic [1:0] {
        ST_RUN      = 2'b00,
        ST_WAIT_RAM = 2'b01,
        ST_INTERNAL = 2'b10,
        ST_HOLD_PIN = 2'b11
    } seq_state_e;

    typedef enum logic [1:0] {
        CAUSE_HW  = 2'b00,
        CAUSE_SW  = 2'b01,
        CAUSE_WDT = 2'b10
    } reset_cause_e;

    typedef struct packed {
        logic [9:0]  data_page_ptr_0;
        logic [9:0]  data_page_ptr_1;
        logic [9:0]  data_page_ptr_2;
        logic [9:0]  data_page_ptr_3;
        logic [15:0] cp;
        logic [15:0] sp;
        logic [15:0] stack_overflow_limit;
        logic [15:0] stack_underflow_limit;
        logic [15:0] system_config_reg;
    } sfr_defaults_s;

    typedef struct packed {
        logic [1:0]  seg;
        logic [15:0] addr;
    } fetch_target_s;

endpackage : reset_seq_pkg

// ===== sync_2ff.sv
`timescale 1ns/1ps

// Two-stage level synchroniser; the first stage feeds only the second
module sync_2ff #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);

    logic stage1;

    // Shift the level through two flops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage1 <= RESET_VAL;
            q      <= RESET_VAL;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end

endmodule : sync_2ff

// ===== system_reset_sequencer.sv
`timescale 1ns/1ps

// What this block does
// - Pin, software or watchdog start internal reset
// - Reset start aborts bus cycles and holds
// - Pending internal RAM write finishes first
// - Restart fetching at 0000h, segment zero
// - Reset output low after any reset
// - Reset output released by end-of-init
// - Registers zero except listed nonzero defaults
// - Reset never touches internal RAM contents
// - Data page pointers load pages 0..3
// - Watchdog runs after reset, overflows 131072 states
// - Watchdog-caused reset sets watchdog reset flag
// - Hardware reset or service clears flag
// - Watchdog disable only before service or end-init
// - Bus type sampled from pins; ROM enable
// - Stack and context pointers load fixed defaults
module system_reset_sequencer
    import reset_seq_pkg::*;
#(
    parameter int RESET_CYCLES   = RESET_CYCLES_DEFAULT,
    parameter int WDT_OVF_CYCLES = reset_seq_pkg::WDT_OVF_CYCLES
) (
    input  wire logic     clk,
    input  wire logic     rst_n,
    input  wire logic     hw_reset_in_n,
    input  wire logic     software_reset_instr,
    input  wire logic     wdt_service_instr,
    input  wire logic     wdt_disable_instr,
    input  wire logic     end_init_instr,
    input  wire logic     ram_write_busy,
    input  wire logic     bus_cfg_pin_0,
    input  wire logic     bus_cfg_pin_1,
    output logic          reset_out_n,
    output logic          core_reset,
    output logic          abort_bus,
    output logic          sfr_load,
    output sfr_defaults_s sfr_defaults,
    output logic          fetch_start,
    output fetch_target_s fetch_target,
    output logic [15:0]   wdt_control_reg,
    output logic          wdt_running,
    output logic          wdt_disable_window
);

    localparam int WDT_TICKS = WDT_OVF_CYCLES / WDT_PRESCALE;
    localparam int RCW       = $clog2(RESET_CYCLES + 1);
    localparam int WCW       = $clog2(WDT_TICKS);
    localparam logic [RCW-1:0] RESET_LAST = RCW'(RESET_CYCLES - 1);
    localparam logic [WCW-1:0] WDT_LAST   = WCW'(WDT_TICKS - 1);
    localparam logic [WCW-1:0] WDT_START  = WCW'(WDT_RELOAD);

    // Refuse parameters the counters cannot serve
    generate
        if (RESET_CYCLES < 1 || WDT_TICKS < 2 || (WDT_OVF_CYCLES % WDT_PRESCALE) != 0) begin : g_bad
            $error("system_reset_sequencer: unsupported parameter values");
        end
    endgenerate

    seq_state_e     state;
    seq_state_e     next_state;
    reset_cause_e   cause;
    reset_cause_e   next_cause;
    logic [RCW-1:0] reset_cnt;
    logic           presc;
    logic [WCW-1:0] wdt_count;
    logic           pin_sync;
    logic           flag;

    // Reset pin level into the clock domain; reads as asserted until seen high,
    // so a pin still low at power-up never lets the sequencer slip into a run
    sync_2ff #(.RESET_VAL(1'b0)) u_pin_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (hw_reset_in_n),
        .q     (pin_sync)
    );

    // Source decode; the pin is expected low long enough
    wire logic hw_low       = !pin_sync;
    wire logic running      = (state == ST_RUN);
    wire logic sw_req       = running && software_reset_instr;
    wire logic wdt_overflow = running && wdt_running && presc && (wdt_count == WDT_LAST);
    wire logic reset_req    = running && (hw_low || sw_req || wdt_overflow);
    wire logic internal_end = (state == ST_INTERNAL) && (reset_cnt == '0);
    wire logic completing   = !running && (next_state == ST_RUN);
    wire logic serviced     = running && wdt_service_instr && !reset_req;
    wire logic disable_ok   = running && wdt_disable_instr && wdt_disable_window && !reset_req;
    wire logic [1:0] bus_cfg = {bus_cfg_pin_1, bus_cfg_pin_0};

    // Reset sequence state transitions
    always_comb begin
        next_state = state;
        unique case (state)
            ST_RUN: begin
                if (reset_req) begin
                    // A RAM write in flight is allowed to land first
                    next_state = ram_write_busy ? ST_WAIT_RAM : ST_INTERNAL;
                end
            end
            ST_WAIT_RAM: begin
                if (!ram_write_busy) begin
                    next_state = ST_INTERNAL;
                end
            end
            ST_INTERNAL: begin
                if (reset_cnt == '0) begin
                    next_state = hw_low ? ST_HOLD_PIN : ST_RUN;
                end
            end
            ST_HOLD_PIN: begin
                if (!hw_low) begin
                    next_state = ST_RUN;
                end
            end
        endcase
    end

    // Cause of the reset in progress; the pin outranks the others
    always_comb begin
        next_cause = cause;
        if (hw_low && (reset_req || !running)) begin
            next_cause = CAUSE_HW;
        end else if (wdt_overflow) begin
            next_cause = CAUSE_WDT;
        end else if (sw_req) begin
            next_cause = CAUSE_SW;
        end
    end

    // Watchdog flag: overflow sets it, pin or service clears it
    wire logic next_flag = (wdt_overflow && !hw_low) ? 1'b1 :
                           (hw_low || serviced)      ? 1'b0 : flag;

    // Sequencer registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state     <= ST_INTERNAL;
            cause     <= CAUSE_HW;
            reset_cnt <= RESET_LAST;
        end else begin
            state     <= next_state;
            cause     <= next_cause;
            reset_cnt <= (next_state == ST_INTERNAL && state != ST_INTERNAL) ? RESET_LAST :
                         (state == ST_INTERNAL && reset_cnt != '0) ? reset_cnt - 1'b1 :
                         reset_cnt;
        end
    end

    // Core hold, bus abort and reset output; internal RAM has no port here
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            core_reset  <= 1'b1;
            abort_bus   <= 1'b1;
            reset_out_n <= 1'b0;
        end else begin
            core_reset <= (next_state != ST_RUN);
            abort_bus  <= (next_state != ST_RUN);
            if (next_state != ST_RUN) begin
                reset_out_n <= 1'b0;
            end else if (running && end_init_instr) begin
                reset_out_n <= 1'b1;
            end
        end
    end

    // Register defaults at the end of internal reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sfr_load     <= 1'b0;
            sfr_defaults <= '0;
        end else begin
            sfr_load <= internal_end;
            if (internal_end) begin
                sfr_defaults.data_page_ptr_0  <= DATA_PAGE_PTR_0_RESET;
                sfr_defaults.data_page_ptr_1  <= DATA_PAGE_PTR_1_RESET;
                sfr_defaults.data_page_ptr_2  <= DATA_PAGE_PTR_2_RESET;
                sfr_defaults.data_page_ptr_3  <= DATA_PAGE_PTR_3_RESET;
                sfr_defaults.cp    <= CP_RESET;
                sfr_defaults.sp    <= SP_RESET;
                sfr_defaults.stack_overflow_limit <= STACK_OVERFLOW_LIMIT_RESET;
                sfr_defaults.stack_underflow_limit <= STACK_UNDERFLOW_LIMIT_RESET;
                sfr_defaults.system_config_reg <= SYSTEM_CONFIG_REG_BASE;
                sfr_defaults.system_config_reg[SYSTEM_CONFIG_REG_BTYP_POS +: 2] <= bus_cfg;
                sfr_defaults.system_config_reg[SYSTEM_CONFIG_REG_ROM_ENABLE_BIT_POS] <= (bus_cfg == BUS_SINGLE_CHIP);
            end
        end
    end

    // Branch to location zero once reset is over
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fetch_start  <= 1'b0;
            fetch_target <= '0;
        end else begin
            fetch_start      <= completing;
            fetch_target.seg  <= FETCH_SEG_RESET;
            fetch_target.addr <= FETCH_ADDR_RESET;
        end
    end

    // Watchdog enable and disable window
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wdt_running        <= 1'b0;
            wdt_disable_window <= 1'b0;
        end else if (completing) begin
            wdt_running        <= 1'b1;
            wdt_disable_window <= 1'b1;
        end else if (!running || reset_req) begin
            wdt_running        <= 1'b0;
            wdt_disable_window <= 1'b0;
        end else begin
            if (disable_ok) begin
                wdt_running <= 1'b0;
            end
            if (wdt_service_instr || end_init_instr) begin
                wdt_disable_window <= 1'b0;
            end
        end
    end

    // Watchdog counter at half clock rate, reloaded on service
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            presc     <= 1'b0;
            wdt_count <= WDT_START;
        end else if (completing || serviced || !running) begin
            presc     <= 1'b0;
            wdt_count <= WDT_START;
        end else if (wdt_running) begin
            presc <= !presc;
            if (presc) begin
                wdt_count <= wdt_count + 1'b1;
            end
        end
    end

    // Watchdog control word with the reset cause flag
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flag            <= 1'b0;
            wdt_control_reg <= WDT_CONTROL_REG_RESET;
        end else begin
            flag            <= next_flag;
            wdt_control_reg <= WDT_CONTROL_REG_RESET;
            wdt_control_reg[WDT_CONTROL_REG_RELOAD_POS +: 8] <= WDT_RELOAD;
            wdt_control_reg[WDT_CONTROL_REG_FLAG_POS] <= next_flag;
        end
    end

    // Checks

    sequence s_reset_done;
        (state == ST_INTERNAL) && (reset_cnt == '0) && !hw_low;
    endsequence

    sequence s_enter_run;
        ##1 (state == ST_RUN) && fetch_start;
    endsequence

    a_hw_start_reset: assert property (@(posedge clk) disable iff (!rst_n)
        running && hw_low |=> !running && core_reset)
        else $error("pin reset did not start the sequence");

    a_bus_aborted: assert property (@(posedge clk) disable iff (!rst_n)
        reset_req |=> abort_bus && !reset_out_n)
        else $error("bus not aborted at reset start");

    a_ram_write_waits: assert property (@(posedge clk) disable iff (!rst_n)
        (state == ST_WAIT_RAM) && ram_write_busy |=> (state == ST_WAIT_RAM) && reset_cnt == $past(reset_cnt))
        else $error("internal reset began during a RAM write");

    a_fetch_from_zero: assert property (@(posedge clk) disable iff (!rst_n)
        s_reset_done |-> s_enter_run ##0 (fetch_target.addr == 16'h0000) && (fetch_target.seg == 2'h0))
        else $error("restart not at address zero");

    a_reset_out_n_held: assert property (@(posedge clk) disable iff (!rst_n)
        (state != ST_RUN) |-> !reset_out_n ##1 (reset_out_n == ($past(end_init_instr) && $past(running)) || $past(reset_out_n) && running || !reset_out_n))
        else $error("reset output high during reset");

    a_reset_out_n_release: assert property (@(posedge clk) disable iff (!rst_n)
        running && end_init_instr && !reset_req |=> reset_out_n)
        else $error("end-of-init did not release reset output");

    a_defaults_value: assert property (@(posedge clk) disable iff (!rst_n)
        sfr_load |-> sfr_defaults.data_page_ptr_3 == 10'h003 && sfr_defaults.data_page_ptr_1 == 10'h001
                     && sfr_defaults.stack_overflow_limit == 16'hFA00 && sfr_defaults.cp == 16'hFC00)
        else $error("wrong register defaults");

    a_system_config_reg_sample: assert property (@(posedge clk) disable iff (!rst_n)
        sfr_load |-> sfr_defaults.system_config_reg[SYSTEM_CONFIG_REG_BTYP_POS +: 2] == $past(bus_cfg)
                     && sfr_defaults.system_config_reg[SYSTEM_CONFIG_REG_ROM_ENABLE_BIT_POS] == ($past(bus_cfg) == 2'h0))
        else $error("bus configuration not sampled");

    a_wdt_overflow: assert property (@(posedge clk) disable iff (!rst_n)
        wdt_overflow |-> wdt_count == WDT_LAST && presc ##1 abort_bus)
        else $error("watchdog overflow misplaced");

    a_wdt_reset_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
        wdt_overflow && !hw_low |=> wdt_control_reg[WDT_CONTROL_REG_FLAG_POS])
        else $error("watchdog reset flag not set");

    a_cause_wdt: assert property (@(posedge clk) disable iff (!rst_n)
        wdt_overflow && !hw_low |=> cause == CAUSE_WDT)
        else $error("watchdog reset cause not recorded");

    a_wdt_reset_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (serviced || hw_low) && !wdt_overflow |=> !wdt_control_reg[WDT_CONTROL_REG_FLAG_POS])
        else $error("watchdog reset flag not cleared");

    a_disable_window: assert property (@(posedge clk) disable iff (!rst_n)
        running && wdt_disable_instr && !wdt_disable_window && !reset_req |=> wdt_running == $past(wdt_running))
        else $error("watchdog disabled outside its window");

endmodule : system_reset_sequencer

// ===== ext_reset_src.sv
`timescale 1ns/1ps

// External reset circuit: capacitor power-on reset plus a warm reset switch
module ext_reset_src #(
    parameter int POR_CYCLES = 8
) (
    input  wire logic clk,
    output logic      hw_reset_in_n
);
    // Pin starts low at power-up and rises once the capacitor charges
    initial begin
        hw_reset_in_n = 1'b0;
        repeat (POR_CYCLES) @(negedge clk);
        hw_reset_in_n = 1'b1;
    end

    // Warm reset: pin held low for n cycles, then back to the pull-up level
    task automatic pulse(input int n);
        @(negedge clk);
        hw_reset_in_n = 1'b0;
        repeat (n) @(negedge clk);
        hw_reset_in_n = 1'b1;
    endtask : pulse
endmodule : ext_reset_src

// ===== tb.sv
`timescale 1ns/1ps

module tb;
    import reset_seq_pkg::*;
    localparam int RC = 2;
    localparam int WC = 16;
    logic          clk, rst_n, hw_n, sw, svc, dis, ei, ram_busy, cfg0, cfg1;
    logic          reset_out_n, core_reset, abort_bus, sfr_load, fetch_start;
    logic          wdt_running, wdt_win;
    logic [15:0]   wdt_reg;
    sfr_defaults_s sfr_def;
    fetch_target_s fetch_tgt;
    int            n_fail;
    int            n_checks;

    system_reset_sequencer #(.RESET_CYCLES(RC), .WDT_OVF_CYCLES(WC)) u_dut (
        .clk(clk), .rst_n(rst_n), .hw_reset_in_n(hw_n), .software_reset_instr(sw),
        .wdt_service_instr(svc), .wdt_disable_instr(dis), .end_init_instr(ei),
        .ram_write_busy(ram_busy), .bus_cfg_pin_0(cfg0), .bus_cfg_pin_1(cfg1),
        .reset_out_n(reset_out_n), .core_reset(core_reset), .abort_bus(abort_bus),
        .sfr_load(sfr_load), .sfr_defaults(sfr_def), .fetch_start(fetch_start),
        .fetch_target(fetch_tgt), .wdt_control_reg(wdt_reg), .wdt_running(wdt_running),
        .wdt_disable_window(wdt_win)
    );

    ext_reset_src u_src (.clk(clk), .hw_reset_in_n(hw_n));

    // Clock at 20 MHz
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Compare one value and count the outcome
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One-cycle instruction pulse: 0 reset, 1 service, 2 disable, 3 end of init
    task automatic instr(input int k);
        @(negedge clk);
        case (k)
            0: sw = 1'b1;
            1: svc = 1'b1;
            2: dis = 1'b1;
            default: ei = 1'b1;
        endcase
        @(negedge clk);
        {sw, svc, dis, ei} = 4'h0;
    endtask : instr

    // Wait for the register load and judge the defaults, then the restart
    task automatic wait_run(input logic [1:0] btyp);
        int i;
        logic [15:0] sc;
        sc = {8'h00, btyp, 6'h00} | ((btyp == 2'h0) ? 16'h0400 : 16'h0000);
        for (i = 0; i < 200 && sfr_load !== 1'b1; i++) @(negedge clk);
        check("sfr_load", {15'h0000, sfr_load}, 16'h0001);
        check("data_page_ptr_0", {6'h00, sfr_def.data_page_ptr_0}, 16'h0000);
        check("data_page_ptr_1", {6'h00, sfr_def.data_page_ptr_1}, 16'h0001);
        check("data_page_ptr_2", {6'h00, sfr_def.data_page_ptr_2}, 16'h0002);
        check("data_page_ptr_3", {6'h00, sfr_def.data_page_ptr_3}, 16'h0003);
        check("cp", sfr_def.cp, 16'hFC00);
        check("sp", sfr_def.sp, 16'hFC00);
        check("stack_underflow_limit", sfr_def.stack_underflow_limit, 16'hFC00);
        check("stack_overflow_limit", sfr_def.stack_overflow_limit, 16'hFA00);
        check("system_config_reg", sfr_def.system_config_reg, sc);
        for (i = 0; i < 200 && fetch_start !== 1'b1; i++) @(negedge clk);
        check("fetch_start", {15'h0000, fetch_start}, 16'h0001);
        check("fetch seg", {14'h0000, fetch_tgt.seg}, 16'h0000);
        check("fetch addr", fetch_tgt.addr, 16'h0000);
        check("core_reset run", {15'h0000, core_reset}, 16'h0000);
        check("out_n low", {15'h0000, reset_out_n}, 16'h0000);
        check("wdt runs", {15'h0000, wdt_running}, 16'h0001);
        check("window", {15'h0000, wdt_win}, 16'h0001);
    endtask : wait_run

    // Software reset held off by a RAM write, then end of init
    task automatic t_sw_ram;
        {cfg1, cfg0} = 2'b10;
        ram_busy = 1'b1;
        instr(0);
        check("core_reset", {15'h0000, core_reset}, 16'h0001);
        check("abort_bus", {15'h0000, abort_bus}, 16'h0001);
        check("out_n", {15'h0000, reset_out_n}, 16'h0000);
        repeat (6) @(negedge clk);
        check("held load", {15'h0000, sfr_load}, 16'h0000);
        check("held abort", {15'h0000, abort_bus}, 16'h0001);
        ram_busy = 1'b0;
        wait_run(2'b10);
        instr(3);
        @(negedge clk);
        check("out_n high", {15'h0000, reset_out_n}, 16'h0001);
        check("window shut", {15'h0000, wdt_win}, 16'h0000);
    endtask : t_sw_ram

    // Late disable ignored; overflow count and flag
    task automatic t_wdt;
        int n;
        instr(2);
        check("late disable", {15'h0000, wdt_running}, 16'h0001);
        instr(1);
        for (n = 0; n < 100 && core_reset !== 1'b1; n++) @(negedge clk);
        check("overflow span", n[15:0], WC[15:0]);
        check("out_n wdt", {15'h0000, reset_out_n}, 16'h0000);
        check("flag set", wdt_reg, 16'h0002);
        wait_run(2'b10);
        check("flag stands", wdt_reg, 16'h0002);
    endtask : t_wdt

    // Pin reset clears the flag; service clears it after a later overflow
    task automatic t_hw_service;
        int n;
        // The register load falls while the pin is still low, so watch in parallel
        fork
            u_src.pulse(6);
            begin
                for (n = 0; n < 20 && core_reset !== 1'b1; n++) @(negedge clk);
                check("hw core_reset", {15'h0000, core_reset}, 16'h0001);
                check("hw out_n", {15'h0000, reset_out_n}, 16'h0000);
                check("hw flag", wdt_reg, 16'h0000);
                wait_run(2'b10);
            end
        join
        for (n = 0; n < 100 && core_reset !== 1'b1; n++) @(negedge clk);
        wait_run(2'b10);
        check("flag again", wdt_reg, 16'h0002);
        instr(1);
        check("svc flag", wdt_reg, 16'h0000);
    endtask : t_hw_service

    // Disable inside the window stops the watchdog
    task automatic t_disable;
        instr(0);
        wait_run(2'b10);
        instr(2);
        check("disabled", {15'h0000, wdt_running}, 16'h0000);
        repeat (3 * WC) @(negedge clk);
        check("no overflow", {15'h0000, core_reset}, 16'h0000);
    endtask : t_disable

    // Report and end the run
    task automatic close_out;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    // Main sequence
    initial begin
        {rst_n, sw, svc, dis, ei, ram_busy, cfg0, cfg1} = 8'h00;
        n_fail = 0;
        n_checks = 0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        wait_run(2'b00);
        check("flag reset", wdt_reg, 16'h0000);
        t_sw_ram;
        t_wdt;
        t_hw_service;
        t_disable;
        close_out;
    end

    // Watchdog against a hang
    initial begin
        #200us;
        n_fail++;
        close_out;
    end
endmodule : tb
